// ===== shared/trace_scan_pkg.sv
// Constants and types for the trace macrocell scan-chain register access path
// What this block does
// [RL1] Registers reached only through TAP chain six
// [RL2] One 40-bit chain: data, address, flag
// [RL3] Host writes: data, address, flag one
// [RL4] Host reads: address and flag zero
// [RL5] Read ignores shifted data field
// [RL6] Access happens only on entering Update-DR
// [RL7] Bit layout LSB first; read data captured
package trace_scan_pkg;

  localparam int unsigned CHAIN_LEN   = 40;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned CHAIN_SEL_W = 4;
  localparam int unsigned PIN_COUNT   = 3;

  // Field positions inside the chain
  localparam int unsigned DATA_LSB  = 0;
  localparam int unsigned DATA_MSB  = 31;
  localparam int unsigned ADDR_LSB  = 32;
  localparam int unsigned ADDR_MSB  = 38;
  localparam int unsigned FLAG_BIT  = 39;

  // Pin positions in the synchroniser bundle
  localparam int unsigned PIN_TCK = 0;
  localparam int unsigned PIN_TMS = 1;
  localparam int unsigned PIN_TDI = 2;

  localparam logic [CHAIN_SEL_W-1:0] TRACE_CHAIN = 4'h6;
  localparam logic                   FLAG_WRITE  = 1'b1;

  // Reset values
  localparam logic [CHAIN_LEN-1:0] CHAIN_RST = 40'h00_0000_0000;
  localparam logic [DATA_W-1:0]    DATA_RST  = 32'h0000_0000;
  localparam logic [ADDR_W-1:0]    ADDR_RST  = 7'h00;
  localparam logic [PIN_COUNT-1:0] PINS_RST  = 3'h0;

  typedef enum logic [3:0] {
    TEST_RESET,
    RUN_IDLE,
    SEL_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SEL_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tap_state_t;

endpackage

// ===== hw/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ===== hw/trace_scan_access.sv
// Trace macrocell register access over the core TAP scan chain
`timescale 1ns/1ps
module trace_scan_access
  import trace_scan_pkg::*;
(
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  tck,
  input  wire logic                                  tms,
  input  wire logic                                  tdi,
  input  wire logic [trace_scan_pkg::CHAIN_SEL_W-1:0] chain_num,
  input  wire logic [trace_scan_pkg::DATA_W-1:0]      reg_rdata,
  output logic                                       tdo,
  output logic                                       tdo_oe_n,
  output logic                                       reg_wr,
  output logic                                       reg_rd,
  output logic      [trace_scan_pkg::ADDR_W-1:0]      reg_addr,
  output logic      [trace_scan_pkg::DATA_W-1:0]      reg_wdata
);

  // Pin side
  logic [PIN_COUNT-1:0] pins_s;
  logic                 tck_prev_q;

  // TAP walk and scan chain
  tap_state_t           state_q;
  tap_state_t           state_d;
  logic [CHAIN_LEN-1:0] chain_q;
  logic [CHAIN_LEN-1:0] chain_d;

  // Held results and output flops
  logic [DATA_W-1:0]    rdata_q;
  logic                 sel_q;
  logic                 tdo_q;
  logic                 tdo_oe_n_q;
  logic                 wr_q;
  logic                 rd_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [DATA_W-1:0]    wdata_q;

  // TCK, TMS and TDI share one delay so their relative timing is kept
  // Each TCK phase must last two clk edges or an edge is missed
  pin_sync #(
    .WIDTH (PIN_COUNT)
  ) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({tdi, tms, tck}),
    .sync_out (pins_s)
  );

  wire tck_s     = pins_s[PIN_TCK];
  wire tms_s     = pins_s[PIN_TMS];
  wire tdi_s     = pins_s[PIN_TDI];
  wire tck_rise  = tck_s & ~tck_prev_q;
  wire tck_fall  = ~tck_s & tck_prev_q;

  wire chain_hit   = (chain_num == TRACE_CHAIN); // RL1
  wire shift_st    = (state_q == SHIFT_DR);
  wire upd_next    = (state_d == UPDATE_DR);
  wire upd_now     = (state_q == UPDATE_DR);
  wire in_capture  = tck_rise & (state_q == CAPTURE_DR);
  wire in_shift    = tck_rise & shift_st;
  // Access fires on the edge that moves the TAP into Update-DR
  wire enter_upd   = tck_rise & upd_next & ~upd_now; // RL6
  wire do_access   = enter_upd & sel_q; // RL1
  wire is_write    = (chain_q[FLAG_BIT] == FLAG_WRITE); // RL3
  wire [ADDR_W-1:0] chain_addr = chain_q[ADDR_MSB:ADDR_LSB]; // RL2
  wire [DATA_W-1:0] chain_data = chain_q[DATA_MSB:DATA_LSB]; // RL2

  // Per-edge actions, decoded here so the flops stay plain
  wire cap_fire    = in_capture & sel_q;
  wire shift_fire  = in_shift & sel_q;
  wire sel_load    = tck_rise & (state_q == SEL_DR) & ~tms_s; // RL1
  wire sel_clear   = tck_rise & (state_q == TEST_RESET);
  wire wr_fire     = do_access & is_write; // RL3
  wire rd_fire     = do_access & ~is_write; // RL4
  wire drive_tdo   = sel_q & shift_st;
  // Capture keeps last address and flag in the top byte
  wire [CHAIN_LEN-1:0] chain_cap = {chain_q[FLAG_BIT:ADDR_LSB], rdata_q}; // RL7
  wire [CHAIN_LEN-1:0] chain_shf = {tdi_s, chain_q[CHAIN_LEN-1:1]}; // RL7

  // Standard TAP state walk on TMS
  always_comb begin
    state_d = state_q;
    case (state_q)
      TEST_RESET: state_d = tms_s ? TEST_RESET : RUN_IDLE;
      RUN_IDLE:   state_d = tms_s ? SEL_DR : RUN_IDLE;
      SEL_DR:     state_d = tms_s ? SEL_IR : CAPTURE_DR;
      CAPTURE_DR: state_d = tms_s ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:   state_d = tms_s ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:   state_d = tms_s ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR:   state_d = tms_s ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:   state_d = tms_s ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR:  state_d = tms_s ? SEL_DR : RUN_IDLE;
      SEL_IR:     state_d = tms_s ? TEST_RESET : CAPTURE_IR;
      CAPTURE_IR: state_d = tms_s ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:   state_d = tms_s ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:   state_d = tms_s ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR:   state_d = tms_s ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:   state_d = tms_s ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR:  state_d = tms_s ? SEL_DR : RUN_IDLE;
      default:    state_d = TEST_RESET;
    endcase
  end

  // Capture loads read data, shift moves LSB first toward TDO
  always_comb begin
    chain_d = chain_q;
    if (cap_fire) begin
      chain_d = chain_cap; // RL7
    end else if (shift_fire) begin
      // Bit 0 leaves first, TDI enters at the flag end
      chain_d = chain_shf; // RL7
    end
  end

  // Idle TCK is low, so this reset value cannot fake a rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  // TAP moves only on a synced TCK rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= TEST_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // Chain only shifts while the whole scan owns chain six
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_q <= CHAIN_RST;
    end else begin
      chain_q <= chain_d; // RL2
    end
  end

  // Selection frozen at Select-DR so a late chain change cannot split a scan
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
    end else if (sel_load) begin
      sel_q <= chain_hit; // RL1
    end else if (sel_clear) begin
      sel_q <= 1'b0;
    end
  end

  // One-cycle strobes toward the trace register file
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= wr_fire; // RL3
    end
  end

  // The file must present read data in the strobe cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
    end else begin
      rd_q <= rd_fire; // RL4
    end
  end

  // Address follows every access, read or write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= ADDR_RST;
    end else if (do_access) begin
      addr_q <= chain_addr; // RL6
    end
  end

  // Write data only loaded on writes; a read leaves it untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_q <= DATA_RST;
    end else if (wr_fire) begin
      wdata_q <= chain_data; // RL5
    end
  end

  // Read result held until the next read strobe replaces it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= DATA_RST;
    end else if (rd_q) begin
      rdata_q <= reg_rdata; // RL7
    end
  end

  // TDO changes on the falling TCK edge, giving the host a half period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= chain_q[DATA_LSB]; // RL7
    end
  end

  // Drive follows the same edge, so the pin never shows stale data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_oe_n_q <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n_q <= ~drive_tdo;
    end
  end

  assign tdo       = tdo_q;
  assign tdo_oe_n  = tdo_oe_n_q;
  assign reg_wr    = wr_q;
  assign reg_rd    = rd_q;
  assign reg_addr  = addr_q;
  assign reg_wdata = wdata_q;

endmodule

// ===== bench/trace_scan_access_chk.sv
// Port assertions for the trace scan access block
`timescale 1ns/1ps
module trace_scan_access_chk
  import trace_scan_pkg::*;
(
  input wire logic                                   clk,
  input wire logic                                   rst_n,
  input wire logic [trace_scan_pkg::CHAIN_SEL_W-1:0] chain_num,
  input wire logic                                   tdo_oe_n,
  input wire logic                                   reg_wr,
  input wire logic                                   reg_rd,
  input wire logic [trace_scan_pkg::ADDR_W-1:0]      reg_addr,
  input wire logic [trace_scan_pkg::DATA_W-1:0]      reg_wdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence strobe_s; reg_wr || reg_rd; endsequence
  sequence quiet_s; !reg_wr && !reg_rd; endsequence
  a_one_strobe: assert property (!(reg_wr && reg_rd))
    else $error("read and write together");
  a_strobe_pulse: assert property (strobe_s |=> quiet_s)
    else $error("strobe too long");
  a_shift_quiet: assert property (!tdo_oe_n |-> quiet_s)
    else $error("access while shifting");
  a_read_keeps: assert property (reg_rd |-> $stable(reg_wdata))
    else $error("read moved write data");
  a_shift_chain: assert property (!tdo_oe_n |-> chain_num == TRACE_CHAIN)
    else $error("shift on wrong chain");
  a_addr_hold: assert property ($changed(reg_addr) |-> strobe_s)
    else $error("address moved without access");
endmodule

// ===== bench/jtag_host_model.sv
// Debug host model driving the JTAG pins
`timescale 1ns/1ps
module jtag_host_model #(
  parameter time HALF = 40ns
) (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Sample late in the high phase, tdo lags the fall by a few clocks
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #HALF tck = 1'b1;
    #HALF o = tdo;
    tck = 1'b0;
  endtask
  task automatic scan(input logic [39:0] din, output logic [39:0] dout);
    logic o;
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < 40; i++) begin
      step(i == 39, din[i], dout[i]);
    end
    // Released data line shows the inverse of its last bit
    step(1'b1, ~din[39], o);
    step(1'b0, ~din[39], o);
  endtask
endmodule

// ===== bench/tb_trace_scan_access.sv
// Self-checking bench for the trace scan access block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_trace_scan_access;
  import trace_scan_pkg::*;
  logic                   clk, rst_n, tck, tms, tdi, tdo, tdo_oe_n, reg_wr, reg_rd, o;
  logic [CHAIN_SEL_W-1:0] chain_num;
  logic [DATA_W-1:0]      reg_rdata, reg_wdata, rdq, wexp, seed;
  logic [ADDR_W-1:0]      reg_addr;
  logic [CHAIN_LEN-1:0]   din, dout, prev;
  logic [CHAIN_LEN:0]     q[$], exp_a;
  int                     failures, compares, cycles, oe_cnt, oe_mark;
  // Drive window: 40 link clocks of 8 clk each
  localparam int          SHIFT_CLKS = CHAIN_LEN * 8;
  trace_scan_access dut_u (.*);
  jtag_host_model host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic final_report();
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    cycles++;
    if (tdo_oe_n === 1'b0) oe_cnt++;
    if (reg_wr === 1'b1 || reg_rd === 1'b1) begin
      // Strobe with nothing queued is an access no scan queued, such as one from the foreign-chain scan
      exp_a = (q.size() != 0) ? q.pop_front() : 'x;
      `CHK("access", exp_a, {reg_rd, reg_wr, reg_addr, reg_wdata})
    end
    if (cycles == 10000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    chain_num = TRACE_CHAIN;
    reg_rdata = DATA_RST;
    seed = 32'h0000_c3f3;
    {rdq, wexp, prev} = '0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    host_u.step(1'b0, 1'b0, o);
    // Writes and back-to-back reads; scan 6 on a foreign chain must not land
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      @(negedge clk) reg_rdata = seed;
      seed = lfsr(seed);
      din = {1'(7'h69 >> i), seed[12:6], ~seed};
      chain_num = (i == 6) ? 4'h5 : TRACE_CHAIN;
      if (i != 6) q.push_back({~din[39], din[39], din[38:32], din[39] ? din[31:0] : wexp});
      if (din[39] && i != 6) wexp = din[31:0];
      oe_mark = oe_cnt;
      host_u.scan(din, dout);
      if (i == 6) `CHK("refused", oe_mark, oe_cnt)
      else begin
        `CHK("scan_out", {prev[39:32], rdq}, dout)
        `CHK("drive", oe_mark + SHIFT_CLKS, oe_cnt)
      end
      `CHK("pending", 1'b0, q.size() != 0)
      if (!din[39]) rdq = reg_rdata;
      if (i != 6) prev = din;
    end
    final_report();
  end
endmodule
bind trace_scan_access trace_scan_access_chk chk_u (.*);
